// ===== core/sce_consts.vh
// Constants for the state compare engine
`ifndef SCE_CONSTS_VH
`define SCE_CONSTS_VH
`define SCE_W          32
`define SCE_AW         10
`define SCE_DEPTH      1024
`define SCE_A_CTRL     4'h0
`define SCE_A_START    4'h1
`define SCE_A_STOP     4'h2
`define SCE_A_MASK     4'h3
`define SCE_A_REFADDR  4'h4
`define SCE_A_REFVAL   4'h5
`define SCE_A_REFCARE  4'h6
`define SCE_A_STATUS   4'h7
`define SCE_A_FINDN    4'h8
`define SCE_A_FINDPOS  4'h9
`define SCE_A_SERIAL   4'ha
`define SCE_A_MMCOUNT  4'hb
`define SCE_A_STORED   4'hc
`define SCE_A_CMD      4'hd
`define SCE_C_PARTIAL  0
`define SCE_C_SRC_LO   1
`define SCE_C_NEQ      3
`define SCE_C_REP      4
`define SCE_C_EXC      5
`define SCE_C_CNTTIME  6
`define SCE_SRC_OFF    2'h0
`define SCE_SRC_XO     2'h1
`define SCE_SRC_CMP    2'h2
`define SCE_MASK_RST   32'hffffffff
`define SCE_SER_MAX    10'h3e7
`endif

// ===== core/sce_engine.v
// State compare engine: reference image, masking, stop logic, mismatch find
`timescale 1ns/1ps
`default_nettype none
`include "sce_consts.vh"
// Functional notes
// - A masked channel is never compared in any state of the image.
// - Mask bit 0 means channel not compared, 1 means compared.
// - Masking only gates comparison; stored reference contents stay untouched.
// - Full or partial compare mode; partial takes start and stop indices.
// - Partial mode compares states from start through stop, both inclusive.
// - Compare stop is evaluated only in repetitive trace mode.
// - Equal stop fires only when every compared bit matches.
// - Not-equal stop fires as soon as any compared bit differs.
// - Either analyzer's stop halts both; the two conditions are ORed.
// - Stop source selects off, marker interval, or compare.
// - Exception storing: acquire, halt, store, resume until storage is full.
// - Each stored exception gets a serial number in its name, incrementing up to 999.
// - Marker interval stop is offered only when count mode is time.
// - Choosing a compare stop replaces any marker interval stop.
// - Mismatches are numbered ascending from listing start, first is one.
// - Find scans states in order to the Nth mismatch, sets current position.
// - Reference images can be saved and restored through the register port.
// - Reference bits can be edited or marked don't-compare, then skipped.
module sce_engine
(
  input  wire                ref_clk,
  input  wire                resetn,
  input  wire                clk_en,
  input  wire [3:0]          reg_addr,
  input  wire [31:0]         reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [31:0]         reg_rdata,
  input  wire                acq_valid,
  input  wire [`SCE_AW-1:0]  acq_index,
  input  wire [`SCE_W-1:0]   acq_data,
  input  wire                acq_last,
  input  wire                xo_hit,
  input  wire                other_stop,
  input  wire                store_done,
  input  wire                storage_full,
  output reg                 own_stop,
  output reg                 halt,
  output reg                 store_req,
  output reg                 state_mismatch,
  output reg  [`SCE_W-1:0]   diff_vec
);

  localparam ST_ACQ   = 2'h0;
  localparam ST_STORE = 2'h1;
  localparam ST_DONE  = 2'h2;

  reg [`SCE_W-1:0]  ref_val  [0:`SCE_DEPTH-1];
  reg [`SCE_W-1:0]  ref_care [0:`SCE_DEPTH-1];
  reg [0:`SCE_DEPTH-1] mm_map;

  reg [6:0]         ctrl_r;
  reg [`SCE_AW-1:0] start_r;
  reg [`SCE_AW-1:0] stop_r;
  reg [`SCE_W-1:0]  mask_r;
  reg [`SCE_AW-1:0] refaddr_r;
  reg [`SCE_AW-1:0] findn_r;
  reg [`SCE_AW-1:0] findpos_r;
  reg [`SCE_AW-1:0] scan_r;
  reg [`SCE_AW:0]   scan_cnt_r;
  reg               find_busy_r;
  reg               found_r;
  reg [9:0]         serial_r;
  reg [`SCE_AW:0]   mmcount_r;
  reg [`SCE_AW:0]   run_mm_r;
  reg               any_mm_r;
  reg [1:0]         st_r;
  reg [31:0]        stored_r;

  wire              partial = ctrl_r[`SCE_C_PARTIAL];
  wire [1:0]        src_sel = ctrl_r[`SCE_C_SRC_LO+1:`SCE_C_SRC_LO];
  wire              neq     = ctrl_r[`SCE_C_NEQ];
  wire              rep     = ctrl_r[`SCE_C_REP];
  wire              exc_en  = ctrl_r[`SCE_C_EXC];
  wire              cnt_tm  = ctrl_r[`SCE_C_CNTTIME];

  // Index lies inside the active compare window
  function in_range;
    input [`SCE_AW-1:0] idx;
    input               part;
    input [`SCE_AW-1:0] lo;
    input [`SCE_AW-1:0] hi;
    begin
      in_range = !part || (idx >= lo && idx <= hi);
    end
  endfunction

  // Differences on compared bits only
  function [`SCE_W-1:0] cmp_diff;
    input [`SCE_W-1:0] a;
    input [`SCE_W-1:0] r;
    input [`SCE_W-1:0] care;
    input [`SCE_W-1:0] msk;
    begin
      cmp_diff = (a ^ r) & care & msk;
    end
  endfunction

  wire [`SCE_W-1:0] cur_diff = cmp_diff(acq_data, ref_val[acq_index],
                                        ref_care[acq_index], mask_r);
  wire              cur_in   = in_range(acq_index, partial, start_r, stop_r);
  wire              cur_mm   = cur_in && (cur_diff != {`SCE_W{1'b0}});
  // Index zero opens a new acquisition, so stale run totals are dropped
  wire              first_st = (acq_index == {`SCE_AW{1'b0}});
  wire              any_prev = any_mm_r && !first_st;
  wire [`SCE_AW:0]  run_prev = first_st ? {(`SCE_AW+1){1'b0}} : run_mm_r;

  // Marker interval stop only honoured in time count mode
  wire xo_ok   = (src_sel == `SCE_SRC_XO) && cnt_tm && xo_hit;
  wire cmp_sel = (src_sel == `SCE_SRC_CMP);
  wire cmp_stop_now = rep && cmp_sel &&
                      (neq ? (acq_valid && cur_mm)
                           : (acq_valid && acq_last && !any_prev
                              && !cur_mm));
  wire own_stop_nxt = (cmp_stop_now || (rep && xo_ok));
  wire any_stop = own_stop || other_stop;

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ctrl_r         <= 7'h00;
      start_r        <= {`SCE_AW{1'b0}};
      stop_r         <= {`SCE_AW{1'b0}};
      mask_r         <= `SCE_MASK_RST;
      refaddr_r      <= {`SCE_AW{1'b0}};
      findn_r        <= {`SCE_AW{1'b0}};
      findpos_r      <= {`SCE_AW{1'b0}};
      scan_r         <= {`SCE_AW{1'b0}};
      scan_cnt_r     <= {(`SCE_AW+1){1'b0}};
      find_busy_r    <= 1'b0;
      found_r        <= 1'b0;
      serial_r       <= 10'h000;
      mmcount_r      <= {(`SCE_AW+1){1'b0}};
      run_mm_r       <= {(`SCE_AW+1){1'b0}};
      any_mm_r       <= 1'b0;
      mm_map         <= {`SCE_DEPTH{1'b0}};
      st_r           <= ST_ACQ;
      stored_r       <= 32'h00000000;
      own_stop       <= 1'b0;
      halt           <= 1'b0;
      store_req      <= 1'b0;
      state_mismatch <= 1'b0;
      diff_vec       <= {`SCE_W{1'b0}};
      reg_rdata      <= 32'h00000000;
    end
    else if (clk_en)
    begin
      reg_rdata <= 32'h00000000;
      if (reg_rd)
      begin
        if (reg_addr == `SCE_A_CTRL)
          reg_rdata <= {25'h0, ctrl_r};
        else if (reg_addr == `SCE_A_START)
          reg_rdata <= {22'h0, start_r};
        else if (reg_addr == `SCE_A_STOP)
          reg_rdata <= {22'h0, stop_r};
        else if (reg_addr == `SCE_A_MASK)
          reg_rdata <= mask_r;
        else if (reg_addr == `SCE_A_REFADDR)
          reg_rdata <= {22'h0, refaddr_r};
        else if (reg_addr == `SCE_A_REFVAL)
          reg_rdata <= ref_val[refaddr_r];
        else if (reg_addr == `SCE_A_REFCARE)
          reg_rdata <= ref_care[refaddr_r];
        else if (reg_addr == `SCE_A_STATUS)
          reg_rdata <= {26'h0, found_r, find_busy_r, st_r, halt, own_stop};
        else if (reg_addr == `SCE_A_FINDN)
          reg_rdata <= {22'h0, findn_r};
        else if (reg_addr == `SCE_A_FINDPOS)
          reg_rdata <= {22'h0, findpos_r};
        else if (reg_addr == `SCE_A_SERIAL)
          reg_rdata <= {22'h0, serial_r};
        else if (reg_addr == `SCE_A_MMCOUNT)
          reg_rdata <= {21'h0, mmcount_r};
        else if (reg_addr == `SCE_A_STORED)
          reg_rdata <= stored_r;
      end
      if (reg_wr)
      begin
        if (reg_addr == `SCE_A_CTRL)
          ctrl_r <= reg_wdata[6:0];
        else if (reg_addr == `SCE_A_START)
          start_r <= reg_wdata[`SCE_AW-1:0];
        else if (reg_addr == `SCE_A_STOP)
          stop_r <= reg_wdata[`SCE_AW-1:0];
        else if (reg_addr == `SCE_A_MASK)
          mask_r <= reg_wdata;
        else if (reg_addr == `SCE_A_REFADDR)
          refaddr_r <= reg_wdata[`SCE_AW-1:0];
        else if (reg_addr == `SCE_A_REFVAL || reg_addr == `SCE_A_REFCARE)
          refaddr_r <= refaddr_r + 1'b1;
        else if (reg_addr == `SCE_A_FINDN)
        begin
          findn_r     <= reg_wdata[`SCE_AW-1:0];
          find_busy_r <= (reg_wdata[`SCE_AW-1:0] != {`SCE_AW{1'b0}});
          found_r     <= 1'b0;
          scan_r      <= {`SCE_AW{1'b0}};
          scan_cnt_r  <= {(`SCE_AW+1){1'b0}};
        end
        else if (reg_addr == `SCE_A_CMD)
        begin
          // Resume from halt, restarting serial numbering on bit 1
          halt     <= 1'b0;
          own_stop <= 1'b0;
          st_r     <= ST_ACQ;
          if (reg_wdata[1])
            serial_r <= 10'h000;
        end
      end
      // Per-state compare result
      state_mismatch <= acq_valid && cur_mm;
      diff_vec <= (acq_valid && cur_in) ? cur_diff : {`SCE_W{1'b0}};
      if (acq_valid)
      begin
        if (first_st)
          mm_map <= {`SCE_DEPTH{1'b0}};
        mm_map[acq_index] <= cur_mm;
        if (acq_last)
        begin
          any_mm_r  <= 1'b0;
          mmcount_r <= run_prev + {{`SCE_AW{1'b0}}, cur_mm};
          run_mm_r  <= {(`SCE_AW+1){1'b0}};
        end
        else
        begin
          any_mm_r <= any_prev | cur_mm;
          run_mm_r <= run_prev + {{`SCE_AW{1'b0}}, cur_mm};
        end
      end
      // Sequential mismatch search
      if (find_busy_r && !(reg_wr && reg_addr == `SCE_A_FINDN))
      begin
        if (mm_map[scan_r] &&
            scan_cnt_r + 1'b1 == {1'b0, findn_r})
        begin
          findpos_r   <= scan_r;
          found_r     <= 1'b1;
          find_busy_r <= 1'b0;
        end
        else
        begin
          if (mm_map[scan_r])
            scan_cnt_r <= scan_cnt_r + 1'b1;
          if (scan_r == {`SCE_AW{1'b1}})
            find_busy_r <= 1'b0;
          else
            scan_r <= scan_r + 1'b1;
        end
      end
      // Stop and exception storing sequence
      case (st_r)
        ST_ACQ:
        begin
          if (own_stop_nxt && !halt)
            own_stop <= 1'b1;
          if (any_stop && !halt)
          begin
            halt <= 1'b1;
            if (rep && exc_en && !storage_full)
            begin
              st_r      <= ST_STORE;
              store_req <= 1'b1;
            end
            else
              st_r <= ST_DONE;
          end
        end
        ST_STORE:
        begin
          store_req <= 1'b0;
          if (store_done)
          begin
            stored_r <= stored_r + 32'h00000001;
            if (serial_r != `SCE_SER_MAX)
              serial_r <= serial_r + 10'h001;
            own_stop <= 1'b0;
            if (storage_full)
              st_r <= ST_DONE;
            else
            begin
              halt <= 1'b0;
              st_r <= ST_ACQ;
            end
          end
        end
        default:
          store_req <= 1'b0;
      endcase
    end
  end

  // Reference image write port, only touched by software
  always @(posedge ref_clk)
  begin
    if (clk_en && reg_wr && reg_addr == `SCE_A_REFVAL)
      ref_val[refaddr_r] <= reg_wdata;
    if (clk_en && reg_wr && reg_addr == `SCE_A_REFCARE)
      ref_care[refaddr_r] <= reg_wdata;
  end

endmodule
`default_nettype wire

// ===== dv/sce_chk.sv
// Port checker for the state compare engine
`timescale 1ns/1ps
`default_nettype none
`include "sce_consts.vh"
module sce_chk
(
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              clk_en,
  input wire logic              reg_rd,
  input wire logic              reg_wr,
  input wire logic              acq_valid,
  input wire logic              xo_hit,
  input wire logic              other_stop,
  input wire logic              store_done,
  input wire logic              storage_full,
  input wire logic              own_stop,
  input wire logic              halt,
  input wire logic              store_req,
  input wire logic              state_mismatch,
  input wire logic [31:0]       reg_rdata,
  input wire logic [`SCE_W-1:0] diff_vec
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_rd; $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_flag; state_mismatch == (diff_vec != 32'h0); endproperty
  a_flag: assert property (p_flag) else $error("flag vs diff");
  property p_own; $rose(own_stop) |-> $past(acq_valid || xo_hit); endproperty
  a_own: assert property (p_own) else $error("stop without cause");
  property p_halt; $rose(own_stop) || $rose(other_stop) |=> halt; endproperty
  a_halt: assert property (p_halt) else $error("halt missing");
  property p_hc; $rose(halt) |-> $past(own_stop || other_stop); endproperty
  a_hc: assert property (p_hc) else $error("halt without stop");
  property p_pulse; store_req |=> !store_req; endproperty
  a_pulse: assert property (p_pulse) else $error("long store req");
  property p_full; halt && storage_full && !reg_wr |=> halt; endproperty
  a_full: assert property (p_full) else $error("resumed when full");
  property p_rel; $fell(halt) |-> $past(store_done || reg_wr); endproperty
  a_rel: assert property (p_rel) else $error("halt dropped");
  c_halt: cover property ($rose(halt));
  c_store: cover property (store_req);
  c_mm: cover property (state_mismatch);
endmodule
`default_nettype wire

// ===== dv/sce_acq_model.sv
// Acquisition memory and storage model facing the compare engine
`timescale 1ns/1ps
`default_nettype none
module sce_acq_model
(
  input  wire logic        ref_clk,
  input  wire logic        start,
  input  wire logic        halt,
  input  wire logic        store_req,
  input  wire logic        slow,
  output logic             acq_valid,
  output logic             acq_last,
  output logic             store_done,
  output logic             busy,
  output logic [9:0]       acq_index,
  output logic [31:0]      acq_data
);
  logic [31:0] mem [16];
  logic [2:0] sd = 3'h0;
  initial
  begin
    {acq_valid, acq_last, busy, acq_index, acq_data} = '0;
    forever
    begin
      @(posedge ref_clk);
      if (start)
      begin
        busy <= 1'b1;
        // Acquisition stops as soon as the engine halts
        for (int i = 0; i < 16 && !halt; i++)
        begin
          acq_valid <= 1'b1;
          acq_index <= 10'(i);
          acq_data <= mem[i];
          acq_last <= i == 15;
          @(posedge ref_clk);
          if (slow)
          begin
            acq_valid <= 1'b0;
            acq_data <= ~mem[i];
            @(posedge ref_clk);
          end
        end
        {acq_valid, acq_last, busy} <= 3'h0;
        acq_data <= ~acq_data;
      end
    end
  end
  // Storage answers each store request three cycles later
  always @(posedge ref_clk) sd <= {sd[1:0], store_req};
  assign store_done = sd[2];
endmodule
`default_nettype wire

// ===== dv/test_state_compare_engine.sv
// Testbench for the state compare engine
`timescale 1ns/1ps
`default_nettype none
`include "sce_consts.vh"
module test_state_compare_engine;
  localparam logic [31:0] REP = 32'h1 << `SCE_C_REP, NEQ = 32'h1 << `SCE_C_NEQ;
  localparam logic [31:0] EXC = 32'h1 << `SCE_C_EXC;
  localparam logic [31:0] TM = 32'h1 << `SCE_C_CNTTIME;
  localparam logic [31:0] CMP = 32'(`SCE_SRC_CMP) << `SCE_C_SRC_LO;
  localparam logic [31:0] XO = 32'(`SCE_SRC_XO) << `SCE_C_SRC_LO;
  logic ref_clk = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic xo_hit = 0, other_stop = 0, storage_full = 0, start = 0, slow = 0;
  logic pv = 0, pt = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 0, msk, v, e, pd, s = 32'h906e606d;
  logic [31:0] rf [16], cr [16];
  logic [9:0] pi, lo, hi;
  wire logic [31:0] reg_rdata, diff_vec, acq_data;
  wire logic [9:0] acq_index;
  wire logic acq_valid, acq_last, store_done, own_stop, halt, store_req;
  wire logic state_mismatch, busy;
  int mismatches = 0, n_tests = 0, cyc = 0, q [$], k, f;
  sce_engine dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acq_valid(acq_valid),
    .acq_index(acq_index), .acq_data(acq_data), .acq_last(acq_last),
    .xo_hit(xo_hit), .other_stop(other_stop), .store_done(store_done),
    .storage_full(storage_full), .own_stop(own_stop), .halt(halt),
    .store_req(store_req), .state_mismatch(state_mismatch),
    .diff_vec(diff_vec)
  );
  sce_acq_model acq_u (
    .ref_clk(ref_clk), .start(start), .halt(halt), .store_req(store_req),
    .slow(slow), .acq_valid(acq_valid), .acq_last(acq_last),
    .store_done(store_done), .busy(busy), .acq_index(acq_index),
    .acq_data(acq_data)
  );
  initial forever #10 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [31:0] xd(logic [9:0] i, logic [31:0] a);
    if (pt && (i < lo || i > hi)) return 32'h0;
    return (a ^ rf[i[3:0]]) & cr[i[3:0]] & msk;
  endfunction
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(logic [31:0] g, logic [31:0] x);
    n_tests++;
    if (g !== x)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdv(logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic run(logic [31:0] c, int nf);
    int j;
    q = {};
    for (int i = 0; i < 16; i++) acq_u.mem[i] = rf[i];
    for (int i = 0; i < nf; i++)
    begin
      j = int'(rnd() % 16);
      acq_u.mem[j] = acq_u.mem[j] ^ (32'h2 << (rnd() % 31)) ^ 32'h1;
    end
    wr(`SCE_A_CTRL, c);
    start <= 1'b1;
    slow <= rnd() > 32'h7fffffff;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (k = 0; k < 200 && busy; k++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  always @(posedge ref_clk)
  begin
    pv <= acq_valid;
    pi <= acq_index;
    pd <= acq_data;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  always @(negedge ref_clk)
    if (pv && resetn)
    begin
      e = xd(pi, pd);
      cmp(diff_vec, e);
      cmp({31'h0, state_mismatch}, {31'h0, |e});
      if (e != 0) q.push_back(int'(pi));
    end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    rdv(`SCE_A_MASK);
    cmp(v, `SCE_MASK_RST);
    rdv(4'hf);
    cmp(v, 32'h0);
    wr(`SCE_A_REFADDR, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      rf[i] = rnd();
      wr(`SCE_A_REFVAL, rf[i]);
    end
    wr(`SCE_A_REFADDR, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      cr[i] = rnd() | rnd() | 32'h1;
      wr(`SCE_A_REFCARE, cr[i]);
    end
    // Masked, partial and single-state ranges, then a mismatch search
    for (int t = 0; t < 6; t++)
    begin
      msk = t[0] ? rnd() : 32'hffffffff;
      pt = t[1];
      lo = 10'(rnd() % 8);
      hi = t == 2 ? lo : 10'(lo + rnd() % 8);
      wr(`SCE_A_MASK, msk);
      wr(`SCE_A_START, 32'(lo));
      wr(`SCE_A_STOP, 32'(hi));
      run(CMP | NEQ | 32'(pt), 4);
      cmp({31'h0, own_stop}, 32'h0);
      rdv(`SCE_A_MMCOUNT);
      cmp(v, 32'(q.size()));
      if (q.size() > 0)
      begin
        f = int'(rnd() % q.size());
        wr(`SCE_A_FINDN, 32'(f + 1));
        for (k = 0; k < 600; k++)
        begin
          rdv(`SCE_A_STATUS);
          if (!v[4]) break;
        end
        cmp({30'h0, v[5:4]}, 32'h2);
        rdv(`SCE_A_FINDPOS);
        cmp(v, 32'(q[f]));
      end
    end
    msk = 32'hffffffff;
    pt = 1'b0;
    wr(`SCE_A_MASK, msk);
    for (int t = 0; t < 4; t++)
    begin
      run(CMP | REP | (t[0] ? NEQ : 32'h0), t / 2);
      e = t[0] ? 32'(q.size() > 0) : 32'(q.size() == 0);
      cmp({31'h0, own_stop}, e);
      cmp({31'h0, halt}, e);
      wr(`SCE_A_CMD, 32'h1);
    end
    other_stop <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 cmp({31'h0, halt}, 32'h1);
    other_stop <= 1'b0;
    wr(`SCE_A_CMD, 32'h1);
    xo_hit <= 1'b1;
    for (int t = 0; t < 3; t++)
    begin
      wr(`SCE_A_CTRL, REP | (t > 0 ? TM : 32'h0) | (t == 2 ? CMP : XO));
      wr(`SCE_A_CMD, 32'h1);
      repeat (4) @(posedge ref_clk);
      #1 cmp({31'h0, own_stop}, 32'(t == 1));
    end
    xo_hit <= 1'b0;
    wr(`SCE_A_CTRL, 32'h0);
    wr(`SCE_A_CMD, 32'h1);
    for (int t = 1; t < 3; t++)
    begin
      storage_full <= t == 2;
      wr(`SCE_A_CMD, 32'h1);
      run(CMP | NEQ | REP | EXC, 1);
      repeat (8) @(posedge ref_clk);
      #1 cmp({31'h0, halt}, 32'(t == 2));
      rdv(`SCE_A_SERIAL);
      cmp(v, 32'h1);
      rdv(`SCE_A_STORED);
      cmp(v, 32'h1);
    end
    wr(`SCE_A_CMD, 32'h3);
    rdv(`SCE_A_SERIAL);
    cmp(v, 32'h0);
    for (int i = 0; i < 16; i += 5)
    begin
      wr(`SCE_A_REFADDR, 32'(i));
      rdv(`SCE_A_REFVAL);
      cmp(v, rf[i]);
      rdv(`SCE_A_REFCARE);
      cmp(v, cr[i]);
    end
    // A write while the clock enable is low must not land
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(`SCE_A_MASK, 32'h0);
    clk_en <= 1'b1;
    rdv(`SCE_A_MASK);
    cmp(v, msk);
    print_verdict();
  end
endmodule
bind sce_engine sce_chk chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .acq_valid(acq_valid), .xo_hit(xo_hit),
  .other_stop(other_stop), .store_done(store_done),
  .storage_full(storage_full), .own_stop(own_stop), .halt(halt),
  .store_req(store_req), .state_mismatch(state_mismatch),
  .reg_rdata(reg_rdata), .diff_vec(diff_vec)
);
`default_nettype wire
